/* File: src/rpc_pump_ctrl.v */
// Chosen here: the APB interface to the registers and the placing of the registers.
`include "rpc_regs.vh"
module rpc_pump_ctrl #(
  parameter LEVEL_W = 16,
  parameter [31:0] MAXRUN_RST = `RPC_MAXRUN_RST,
  parameter [31:0] VDLY_RST = `RPC_VDLY_RST,
  parameter [31:0] TICK_NS = `RPC_TICK_NS
) (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire start_level_contact,
  input wire stop_level_contact,
  input wire [LEVEL_W-1:0] can_level,
  input wire [18:0] can_level_spn,
  input wire can_level_valid,
  input wire gen_avail,
  input wire loads_avail,
  input wire mains_avail,
  input wire off_reset_state,
  input wire [7:0] event_log_mask,
  output reg pump_cmd_q,
  output reg valve_cmd_q,
  output reg pump_overrun_prealarm,
  output reg pump_on_event,
  output reg pump_off_event
);
  localparam [31:0] TICK_CYC = TICK_NS / `RPC_CLK_NS;
  // Control register: mode, manual request, alarm acknowledge.
  reg [1:0] mode_q;
  reg man_req_q;
  // Configuration: output functions, contacts present, power source.
  reg pump_output_function_q;
  reg valve_output_function_q;
  reg contacts_cfg_q;
  reg [2:0] src_q;
  reg [LEVEL_W-1:0] thr_on_q;
  reg [LEVEL_W-1:0] thr_off_q;
  reg [31:0] maxrun_q;
  reg [31:0] vdly_q;
  reg [LEVEL_W-1:0] level_q;
  reg [1:0] pos_q;
  reg want_q;
  reg [31:0] tick_cnt_q;
  reg [31:0] run_ms_q;
  reg [31:0] vdly_ms_q;
  reg ack_q;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  wire tick = (tick_cnt_q == TICK_CYC - 32'h1);
  // Source availability map; an unsupported code counts as absent.
  reg src_ok;
  always @* begin
    case (src_q)
      `RPC_SRC_GEN: src_ok = gen_avail;
      `RPC_SRC_LOADS: src_ok = loads_avail;
      `RPC_SRC_MAINS: src_ok = mains_avail;
      `RPC_SRC_ALWAYS: src_ok = 1'b1;
      default: src_ok = 1'b0;
    endcase
  end
  // Level position; thresholds assume on below off, which software keeps.
  reg [1:0] pos_d;
  always @* begin
    if (contacts_cfg_q) begin
      if (start_level_contact)
        pos_d = `RPC_POS_START;
      else if (!stop_level_contact)
        pos_d = `RPC_POS_STOP;
      else
        pos_d = `RPC_POS_HYST;
    end else begin
      if (level_q < thr_on_q)
        pos_d = `RPC_POS_START;
      else if (level_q > thr_off_q)
        pos_d = `RPC_POS_STOP;
      else
        pos_d = `RPC_POS_HYST;
    end
  end
  // Demand before the protective gates.
  reg want_d;
  always @* begin
    case (mode_q)
      `RPC_MODE_AUTO: begin
        if (pos_q == `RPC_POS_START)
          want_d = 1'b1;
        else if (pos_q == `RPC_POS_STOP)
          want_d = 1'b0;
        else
          want_d = want_q;
      end
      `RPC_MODE_RUN: want_d = man_req_q & (pos_q != `RPC_POS_STOP);
      `RPC_MODE_INHIBIT: want_d = 1'b0;
      default: want_d = 1'b0;
    endcase
  end
  wire allow = pump_output_function_q & src_ok & ~off_reset_state & ~pump_overrun_prealarm;
  wire run_req = want_q & allow;
  wire vdly_done = (vdly_ms_q >= vdly_q);
  wire pump_d = run_req & (~valve_output_function_q | vdly_done);
  wire valve_d = run_req & valve_output_function_q;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q <= `RPC_MODE_AUTO;
      man_req_q <= 1'b0;
      pump_output_function_q <= 1'b0;
      valve_output_function_q <= 1'b0;
      contacts_cfg_q <= 1'b0;
      src_q <= `RPC_SRC_ALWAYS;
      thr_on_q <= `RPC_THR_ON_RST;
      thr_off_q <= `RPC_THR_OFF_RST;
      maxrun_q <= MAXRUN_RST;
      vdly_q <= VDLY_RST;
      level_q <= {LEVEL_W{1'b0}};
      pos_q <= `RPC_POS_HYST;
      want_q <= 1'b0;
      tick_cnt_q <= 32'h0;
      run_ms_q <= 32'h0;
      vdly_ms_q <= 32'h0;
      ack_q <= 1'b0;
      pump_cmd_q <= 1'b0;
      valve_cmd_q <= 1'b0;
      pump_overrun_prealarm <= 1'b0;
      pump_on_event <= 1'b0;
      pump_off_event <= 1'b0;
    end else if (clk_en) begin
      ack_q <= 1'b0;
      if (wr) begin
        case (paddr)
          `RPC_ADDR_CTRL: begin
            mode_q <= pwdata[1:0];
            if (pwdata[2] && pos_q != `RPC_POS_STOP)
              man_req_q <= 1'b1;
            if (pwdata[3])
              man_req_q <= 1'b0;
            ack_q <= pwdata[4];
          end
          `RPC_ADDR_CFG: begin
            pump_output_function_q <= pwdata[0];
            valve_output_function_q <= pwdata[1];
            contacts_cfg_q <= pwdata[2];
            src_q <= pwdata[6:4];
          end
          `RPC_ADDR_THR: begin
            thr_on_q <= pwdata[LEVEL_W-1:0];
            thr_off_q <= pwdata[31:32-LEVEL_W];
          end
          `RPC_ADDR_MAXRUN: maxrun_q <= pwdata;
          `RPC_ADDR_VDLY: vdly_q <= pwdata;
          default: ;
        endcase
      end
      if (can_level_valid && can_level_spn == `RPC_LEVEL_SPN)
        level_q <= can_level;
      pos_q <= pos_d;
      want_q <= want_d;
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      // Valve lead time counts while a run is requested.
      if (!run_req)
        vdly_ms_q <= 32'h0;
      else if (tick && !vdly_done)
        vdly_ms_q <= vdly_ms_q + 32'h1;
      // Run timer measures continuous pump running in milliseconds.
      if (!pump_cmd_q)
        run_ms_q <= 32'h0;
      else if (tick)
        run_ms_q <= run_ms_q + 32'h1;
      // Overrun wins over an acknowledge in the same cycle.
      if (pump_cmd_q && tick && run_ms_q + 32'h1 >= maxrun_q)
        pump_overrun_prealarm <= 1'b1;
      else if (ack_q)
        pump_overrun_prealarm <= 1'b0;
      pump_cmd_q <= pump_d;
      valve_cmd_q <= valve_d;
      pump_on_event <= event_log_mask[`RPC_EVT_BIT] & pump_d & ~pump_cmd_q;
      pump_off_event <= event_log_mask[`RPC_EVT_BIT] & ~pump_d & pump_cmd_q;
    end
  end
  // Zero-wait read mux; unmapped addresses read zero.
  always @* begin
    prdata = 32'h0;
    case (paddr)
      `RPC_ADDR_CTRL: prdata = {29'h0, man_req_q, mode_q};
      `RPC_ADDR_CFG: prdata = {25'h0, src_q, 1'b0, contacts_cfg_q,
        valve_output_function_q, pump_output_function_q};
      `RPC_ADDR_THR: prdata = {thr_off_q, thr_on_q};
      `RPC_ADDR_MAXRUN: prdata = maxrun_q;
      `RPC_ADDR_VDLY: prdata = vdly_q;
      `RPC_ADDR_STAT: prdata = {24'h0, src_ok, pump_overrun_prealarm, pos_q,
        2'h0, valve_cmd_q, pump_cmd_q};
      `RPC_ADDR_CMD: prdata = {30'h0, valve_cmd_q, pump_cmd_q};
      default: prdata = 32'h0;
    endcase
  end
endmodule // rpc_pump_ctrl

/* File: src/rpc_regs.vh */
`ifndef RPC_REGS_VH
`define RPC_REGS_VH
`define RPC_ADDR_CTRL 12'h000
`define RPC_ADDR_CFG 12'h004
`define RPC_ADDR_THR 12'h008
`define RPC_ADDR_MAXRUN 12'h00c
`define RPC_ADDR_VDLY 12'h010
`define RPC_ADDR_STAT 12'h014
`define RPC_ADDR_CMD 12'h018
`define RPC_MODE_AUTO 2'h0
`define RPC_MODE_RUN 2'h1
`define RPC_MODE_INHIBIT 2'h2
`define RPC_SRC_GEN 3'h0
`define RPC_SRC_LOADS 3'h2
`define RPC_SRC_MAINS 3'h3
`define RPC_SRC_ALWAYS 3'h4
`define RPC_POS_HYST 2'h0
`define RPC_POS_START 2'h1
`define RPC_POS_STOP 2'h2
`define RPC_EVT_BIT 7
`define RPC_LEVEL_SPN 19'h006e1
`define RPC_THR_ON_RST 16'h0014
`define RPC_THR_OFF_RST 16'h0050
`define RPC_MAXRUN_RST 32'h0000ea60
`define RPC_VDLY_RST 32'h00000032
`define RPC_TICK_NS 1000000
`define RPC_CLK_NS 20
`endif

/* File: tb/rpc_pump_ctrl_monitor.sv */
module rpc_pump_ctrl_monitor (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire off_reset_state,
  input wire [7:0] event_log_mask,
  input wire pump_cmd_q,
  input wire valve_cmd_q,
  input wire pump_overrun_prealarm,
  input wire pump_on_event,
  input wire pump_off_event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst || !clk_en);
  valve_drop_a: assert property ($fell(pump_cmd_q) |-> !valve_cmd_q)
    else $error("valve open after pump stop");
  valve_lead_a: assert property ($rose(pump_cmd_q) && valve_cmd_q |-> $past(valve_cmd_q))
    else $error("valve not ahead of pump");
  on_evt_a: assert property ($rose(pump_cmd_q) && event_log_mask[7] |-> pump_on_event)
    else $error("missing on event");
  on_cause_a: assert property (pump_on_event |-> $rose(pump_cmd_q))
    else $error("stray on event");
  off_cause_a: assert property (pump_off_event |-> $fell(pump_cmd_q))
    else $error("stray off event");
  off_reset_a: assert property (off_reset_state [*4] |-> !pump_cmd_q)
    else $error("pump on in off state");
  overrun_off_a: assert property (pump_overrun_prealarm [*4] |-> !pump_cmd_q)
    else $error("pump on during overrun");
  stat_view_a: assert property (psel && penable && paddr == 12'h014
    |-> prdata[1:0] == {valve_cmd_q, pump_cmd_q}) else $error("status mismatch");
endmodule // rpc_pump_ctrl_monitor

bind rpc_pump_ctrl rpc_pump_ctrl_monitor rpc_pump_ctrl_monitor_inst (.ref_clk, .nrst, .clk_en,
  .psel, .penable, .paddr, .prdata, .off_reset_state, .event_log_mask, .pump_cmd_q,
  .valve_cmd_q, .pump_overrun_prealarm, .pump_on_event, .pump_off_event);

/* File: tb/rpc_tank_model.sv */
module rpc_tank_model (
  input wire [15:0] level,
  output wire start_closed,
  output wire stop_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both contacts open only when full, so a broken wire reads as a full tank.
  assign start_closed = level < 16'h0014;
  assign stop_closed = level < 16'h0050;
endmodule // rpc_tank_model

/* File: tb/rpc_pump_ctrl_tb_top.sv */
`include "rpc_regs.vh"
module rpc_pump_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, off_reset_state = 0;
  logic clk_en = 1'h1;
  logic [7:0] log_mask = 8'h80;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] lvl = 16'h000a, can_level = 16'h0064;
  logic [2:0] avail = 0;
  logic [2:0] src [3] = '{3'h0, 3'h2, 3'h3};
  logic pready, pslverr, start_c, stop_c, pump_cmd_q, valve_cmd_q, pump_overrun_prealarm;
  logic pump_on_event, pump_off_event;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  initial forever #10 ref_clk = ~ref_clk;
  rpc_tank_model rpc_tank_model_inst (.level(lvl), .start_closed(start_c), .stop_closed(stop_c));
  rpc_pump_ctrl #(.MAXRUN_RST(32'h14), .VDLY_RST(32'h2), .TICK_NS(32'h64)) rpc_pump_ctrl_inst (
    .ref_clk, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .start_level_contact(start_c), .stop_level_contact(stop_c),
    .can_level, .can_level_spn(`RPC_LEVEL_SPN), .can_level_valid(1'h1), .gen_avail(avail[0]),
    .loads_avail(avail[1]), .mains_avail(avail[2]), .off_reset_state, .event_log_mask(log_mask),
    .pump_cmd_q, .valve_cmd_q, .pump_overrun_prealarm, .pump_on_event, .pump_off_event);
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    r = prdata;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(r, e, nm);
  endtask
  // Waits are bounded since the tick phase makes the valve lead vary by one tick.
  task automatic wp(input logic v);
    repeat (300) if (pump_cmd_q !== v) @(posedge ref_clk);
    chk(pump_cmd_q, v, "pump");
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(`RPC_ADDR_CFG, 32'h40, "cfg");
    rd(`RPC_ADDR_THR, 32'h00500014, "thr");
    chk(pump_cmd_q, 1'h0, "pump");
    apb(1'h1, `RPC_ADDR_CFG, 32'h47);
    repeat (4) @(posedge ref_clk);
    chk({valve_cmd_q, pump_cmd_q}, 2'h2, "valve first");
    wp(1'h1);
    lvl <= 16'h0032;
    repeat (10) @(posedge ref_clk);
    chk(pump_cmd_q, 1'h1, "hold");
    lvl <= 16'h0064;
    wp(1'h0);
    chk(valve_cmd_q, 1'h0, "valve");
    rd(`RPC_ADDR_STAT, 32'ha0, "stat");
    lvl <= 16'h000a;
    wp(1'h1);
    repeat (300) if (pump_overrun_prealarm !== 1'h1) @(posedge ref_clk);
    chk(pump_overrun_prealarm, 1'h1, "prealarm");
    wp(1'h0);
    apb(1'h1, `RPC_ADDR_CTRL, 32'h10);
    wp(1'h1);
    rd(`RPC_ADDR_CTRL, 32'h0, "ctrl");
    apb(1'h1, `RPC_ADDR_CTRL, 32'h2);
    wp(1'h0);
    apb(1'h1, `RPC_ADDR_CTRL, 32'h1);
    lvl <= 16'h0064;
    apb(1'h1, `RPC_ADDR_CTRL, 32'h5);
    rd(`RPC_ADDR_CTRL, 32'h1, "ctrl");
    lvl <= 16'h000a;
    apb(1'h1, `RPC_ADDR_CTRL, 32'h5);
    wp(1'h1);
    lvl <= 16'h0064;
    wp(1'h0);
    lvl <= 16'h0032;
    wp(1'h1);
    off_reset_state <= 1'h1;
    wp(1'h0);
    off_reset_state <= 1'h0;
    apb(1'h1, `RPC_ADDR_CTRL, 32'h0);
    lvl <= 16'h000a;
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, `RPC_ADDR_CFG, {25'h0, src[i], 4'h7});
      wp(1'h0);
      avail <= 3'h1 << i;
      wp(1'h1);
      avail <= 3'h0;
    end
    apb(1'h1, `RPC_ADDR_CFG, 32'h43);
    wp(1'h0);
    can_level <= 16'h000a;
    wp(1'h1);
    // A low enable must freeze the running command although the level says stop.
    clk_en <= 1'h0;
    can_level <= 16'h0064;
    repeat (10) @(posedge ref_clk);
    chk(pump_cmd_q, 1'h1, "frozen");
    clk_en <= 1'h1;
    wp(1'h0);
    complete_run();
  end
endmodule // rpc_pump_ctrl_tb_top
